// >>> logic/sdw_pkg.sv
// Purpose: shared constants for the serial converter write control
// Assumes: 16-bit frames, mode bits in positions 13:12, code in 11:0
// Notes:   modes and register map used by the control block
package sdw_pkg;

	// ----------------------------------------------------------------
	// frame layout
	// ----------------------------------------------------------------
	localparam int FRAME_BITS   = 16;
	localparam int CODE_BITS    = 12;
	localparam int MODE_HI_POS  = 13;
	localparam int MODE_LO_POS  = 12;
	localparam int CODE_MSB_POS = 11;
	localparam logic [4:0] LAST_EDGE = 5'h10;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] CTRL_OFS   = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] COUNT_OFS  = 8'h08;

	localparam logic [11:0] CODE_RESET = 12'h000;
	localparam logic [1:0]  MODE_RESET = 2'h0;

	// ----------------------------------------------------------------
	// operating modes
	// ----------------------------------------------------------------
	typedef enum logic [1:0]
	{
		SDW_NORMAL   = 2'h0,
		SDW_PD_1K    = 2'h1,
		SDW_PD_100K  = 2'h2,
		SDW_PD_HIZ   = 2'h3
	} sdw_mode_e;

endpackage

// >>> logic/sdw_ctrl.sv
// Purpose: serial write control of a 12-bit voltage-output converter
// Assumes: link pins asynchronous to clk_i, sampled by two flops each;
//          link clock well below half of clk_i
// Notes:   AXI4-Lite slave gives status and a frame-enable control
//
// Contract
// - While select is low in an enabled frame, data is sampled on each falling shift edge up to the sixteenth.
// - On the sixteenth falling edge the word is applied at once.
// - Select may stay low or rise after that; a new falling select restarts while enable is set.
// - Select rising before edge sixteen discards the frame unchanged.
// - The first two bits are ignored; the next two choose the mode.
// - Mode 00 normal, 01 1k pulldown, 10 100k pulldown, 11 high-Z.
// - After reset the code is zero until the first valid write.
// - Power-down frames still load their code bits; normal mode resumes with the last code loaded.
// - The code is unsigned straight binary from 0 to 4095.
// - The code selects exactly one of 4096 string taps.
`timescale 1ns/1ns

module sdw_ctrl
	import sdw_pkg::*;
(
	input  wire logic                 clk_i,
	input  wire logic                 reset_i,
	input  wire logic                 sync_n_i,
	input  wire logic                 sclk_i,
	input  wire logic                 din_i,
	output logic [CODE_BITS-1:0]      code_o,
	output logic [4095:0]             tap_sel_o,
	output logic                      powered_o,
	output logic                      pd_1k_o,
	output logic                      pd_100k_o,
	output logic                      pd_hiz_o,
	input  wire logic [7:0]           s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [7:0]           s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed
	{
		logic [1:0]            sync_sy;
		logic [1:0]            sclk_sy;
		logic [1:0]            din_sy;
		logic                  sync_d;
		logic                  sclk_d;
		logic                  active;
		logic                  done;
		logic [4:0]            edges;
		logic [FRAME_BITS-1:0] shift;
		logic [CODE_BITS-1:0]  code;
		sdw_mode_e             mode;
		logic                  enable;
		logic [15:0]           frames;
		logic [15:0]           aborts;
		logic                  aw_held;
		logic [7:0]            aw_addr;
		logic                  w_held;
		logic [31:0]           w_data;
		logic [3:0]            w_strb;
		logic                  bvalid;
		logic                  rvalid;
		logic [31:0]           rdata;
		logic [1:0]            rresp;
		logic [1:0]            bresp;
	} sdw_state_s;

	sdw_state_s st;
	sdw_state_s next_st;

	logic sync_low;
	logic sclk_fall;
	logic sync_fall;
	logic sync_rise;
	logic [FRAME_BITS-1:0] word;

	// only the second synchroniser stage feeds logic
	assign sync_low  = !st.sync_sy[1];
	assign sclk_fall = st.sclk_d && !st.sclk_sy[1];
	assign sync_fall = st.sync_d && !st.sync_sy[1];
	assign sync_rise = !st.sync_d && st.sync_sy[1];
	assign word      = {st.shift[FRAME_BITS-2:0], st.din_sy[1]};

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		next_st = st;
		next_st.sync_sy = {st.sync_sy[0], sync_n_i};
		next_st.sclk_sy = {st.sclk_sy[0], sclk_i};
		next_st.din_sy  = {st.din_sy[0], din_i};
		next_st.sync_d  = st.sync_sy[1];
		next_st.sclk_d  = st.sclk_sy[1];

		// a falling select opens a fresh frame only while enable is set
		if (sync_fall && st.enable)
		begin
			next_st.active = 1'b1;
			next_st.done   = 1'b0;
			next_st.edges  = 5'h00;
			next_st.shift  = '0;
		end
		else if (sync_rise)
		begin
			if (st.active && !st.done)
				next_st.aborts = st.aborts + 16'h0001;
			next_st.active = 1'b0;
			next_st.edges  = 5'h00;
			next_st.shift  = '0;
		end
		else if (st.active && !st.done && sync_low && sclk_fall)
		begin
			next_st.shift = word;
			next_st.edges = st.edges + 5'h01;
			if (st.edges + 5'h01 == LAST_EDGE)
			begin
				// extra edges after the word are ignored until reselect
				next_st.done   = 1'b1;
				// top two bits are don't-cares
				next_st.mode   = sdw_mode_e'(word[MODE_HI_POS:MODE_LO_POS]);
				next_st.code   = word[CODE_MSB_POS:0];
				next_st.frames = st.frames + 16'h0001;
			end
		end

		// AXI4-Lite write: address and data taken in either order
		if (s_axi_awvalid && s_axi_awready)
		begin
			next_st.aw_held = 1'b1;
			next_st.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			next_st.w_held = 1'b1;
			next_st.w_data = s_axi_wdata;
			next_st.w_strb = s_axi_wstrb;
		end
		if (st.aw_held && st.w_held && !st.bvalid)
		begin
			next_st.aw_held = 1'b0;
			next_st.w_held  = 1'b0;
			next_st.bvalid  = 1'b1;
			next_st.bresp   = 2'h0;
			if (st.aw_addr[7:2] == CTRL_OFS[7:2])
			begin
				if (st.w_strb[0])
					next_st.enable = st.w_data[0];
			end
			else if (st.aw_addr[7:2] != STATUS_OFS[7:2]
				&& st.aw_addr[7:2] != COUNT_OFS[7:2])
				next_st.bresp = 2'h2;
		end
		if (st.bvalid && s_axi_bready)
			next_st.bvalid = 1'b0;

		if (s_axi_arvalid && s_axi_arready)
		begin
			next_st.rvalid = 1'b1;
			next_st.rresp  = 2'h0;
			unique case (s_axi_araddr[7:2])
				CTRL_OFS[7:2]:
					next_st.rdata = {31'h0, st.enable};
				STATUS_OFS[7:2]:
					next_st.rdata = {12'h0, st.code, 3'h0, st.active,
						st.done, 1'b0, st.mode};
				COUNT_OFS[7:2]:
					next_st.rdata = {st.aborts, st.frames};
				default:
				begin
					next_st.rdata = 32'h0;
					next_st.rresp = 2'h2;
				end
			endcase
		end
		else if (st.rvalid && s_axi_rready)
			next_st.rvalid = 1'b0;
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			st         <= '0;
			st.sync_sy <= 2'h3;
			st.sync_d  <= 1'b1;
			st.code    <= CODE_RESET;
			st.mode    <= sdw_mode_e'(MODE_RESET);
			st.enable  <= 1'b1;
		end
		else
		begin
			st <= next_st;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign s_axi_awready = !st.aw_held;
	assign s_axi_wready  = !st.w_held;
	assign s_axi_bvalid  = st.bvalid;
	assign s_axi_bresp   = st.bresp;
	assign s_axi_arready = !st.rvalid;
	assign s_axi_rvalid  = st.rvalid;
	assign s_axi_rdata   = st.rdata;
	assign s_axi_rresp   = st.rresp;

	assign code_o    = st.code;
	assign powered_o = (st.mode == SDW_NORMAL);
	assign pd_1k_o   = (st.mode == SDW_PD_1K);
	assign pd_100k_o = (st.mode == SDW_PD_100K);
	assign pd_hiz_o  = (st.mode == SDW_PD_HIZ);

	// one-hot tap select; monotonic by construction
	always_comb
	begin
		tap_sel_o = '0;
		tap_sel_o[st.code] = 1'b1;
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_abort_keeps_code: assert property (
		@(posedge clk_i) disable iff (reset_i)
		(sync_rise && st.active && !st.done)
		|=> $stable(st.code) && $stable(st.mode))
		else $error("aborted frame changed code or mode");

	a_abort_counted: assert property (
		@(posedge clk_i) disable iff (reset_i)
		(sync_rise && st.active && !st.done)
		|=> st.aborts == $past(st.aborts) + 16'h0001)
		else $error("aborted frame not counted");

	a_abort_clears: assert property (
		@(posedge clk_i) disable iff (reset_i)
		sync_rise
		|=> !st.active && st.edges == 5'h00 && st.shift == '0)
		else $error("shift register not cleared on select rise");

	a_idle_no_edges: assert property (
		@(posedge clk_i) disable iff (reset_i)
		!st.active |-> st.edges == 5'h00)
		else $error("edges counted outside a frame");

	a_apply_on_last: assert property (
		@(posedge clk_i) disable iff (reset_i)
		(st.active && !st.done && sync_low && sclk_fall && !sync_fall
		&& st.edges == 5'h0f)
		|=> st.done && st.code == $past(word[CODE_MSB_POS:0]))
		else $error("word not applied on last edge");

	a_mode_from_word: assert property (
		@(posedge clk_i) disable iff (reset_i)
		(st.active && !st.done && sync_low && sclk_fall && !sync_fall
		&& st.edges == 5'h0f)
		|=> st.mode == $past(word[MODE_HI_POS:MODE_LO_POS]))
		else $error("mode bits not taken from the word");

	a_frame_counted: assert property (
		@(posedge clk_i) disable iff (reset_i)
		$rose(st.done) |-> st.frames == $past(st.frames) + 16'h0001)
		else $error("complete frame not counted");

	a_late_edges_ignored: assert property (
		@(posedge clk_i) disable iff (reset_i)
		(st.done && sclk_fall && !sync_fall && !sync_rise)
		|=> $stable(st.shift) && $stable(st.edges))
		else $error("edge after the word was shifted");

	a_mode_decode: assert property (
		@(posedge clk_i) disable iff (reset_i)
		$changed(st.mode) |-> $rose(st.done))
		else $error("mode changed outside a complete frame");

	a_code_only_done: assert property (
		@(posedge clk_i) disable iff (reset_i)
		$changed(st.code) |-> $rose(st.done))
		else $error("code changed outside a complete frame");

	a_reset_zero_code: assert property (
		@(posedge clk_i) disable iff (reset_i)
		$fell(reset_i) |-> code_o == CODE_RESET && powered_o)
		else $error("reset did not clear the code");

	a_shift_on_fall: assert property (
		@(posedge clk_i) disable iff (reset_i)
		(st.active && !st.done && sync_low && sclk_fall && !sync_fall
		&& !sync_rise) |=> st.edges == $past(st.edges) + 5'h01)
		else $error("falling edge not counted");

	a_shift_msb_first: assert property (
		@(posedge clk_i) disable iff (reset_i)
		(st.active && !st.done && sync_low && sclk_fall && !sync_fall
		&& !sync_rise) |=> st.shift == $past(word))
		else $error("bit not shifted in at the bottom");

	a_restart_clears: assert property (
		@(posedge clk_i) disable iff (reset_i)
		(sync_fall && st.enable)
		|=> st.active && st.edges == 5'h00 && !st.done)
		else $error("new frame not started");

	a_start_when_enabled: assert property (
		@(posedge clk_i) disable iff (reset_i)
		$rose(st.active) |-> $past(st.enable))
		else $error("frame opened while reception was off");

	a_one_tap: assert property (
		@(posedge clk_i) disable iff (reset_i)
		$onehot(tap_sel_o) && tap_sel_o[code_o])
		else $error("tap select not one-hot");

	a_edges_bound: assert property (
		@(posedge clk_i) disable iff (reset_i)
		st.edges <= LAST_EDGE)
		else $error("edge count ran past the word");

	a_mode_outputs: assert property (
		@(posedge clk_i) disable iff (reset_i)
		$onehot({powered_o, pd_1k_o, pd_100k_o, pd_hiz_o}))
		else $error("mode outputs not exclusive");

endmodule

// >>> testbench/sdw_host_model.sv
// Purpose: host end of the serial write link, frames sent msb first
// Assumes: 80 ns shift clock, frames started by calls to send
// Notes:   shift clock stands low between frames
`timescale 1ns/1ns

module sdw_host_model
(
	output logic sync_n_o,
	output logic sclk_o,
	output logic din_o
);
	initial
	begin
		sync_n_o = 1'b1;
		sclk_o   = 1'b0;
		din_o    = 1'b0;
	end

	// ----------------------------------------------------------------
	// one frame; fewer than 16 bits raises select early, extra bits are 0
	// ----------------------------------------------------------------
	task automatic send(input logic [15:0] word, input int n_bits);
		// offset keeps link edges apart from the system clock edges
		#7;
		sync_n_o = 1'b0;
		#20;
		for (int i = 15; i > 15 - n_bits; i--)
		begin
			din_o = (i < 0) ? 1'b0 : word[i];
			#20 sclk_o = 1'b1;
			#40 sclk_o = 1'b0;
			// data held past the fall, the sampler sees it two flops late
			#20;
		end
		din_o = 1'b0;
		sync_n_o = 1'b1;
		#80;
	endtask
endmodule

// >>> testbench/sdw_ctrl_tb.sv
// Purpose: self-checking bench of the converter write control
// Assumes: host model drives the link, tasks drive the register bus
// Notes:   outputs are checked a fixed settle time after each frame
`timescale 1ns/1ns

module sdw_ctrl_tb
	import sdw_pkg::*;
;
	logic        clk_i, reset_i, powered_o, pd_1k_o, pd_100k_o, pd_hiz_o;
	wire         sync_n, sclk, din;
	logic [11:0] code_o;
	logic [4095:0] tap_sel_o;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rs, bs;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	int          mismatches, n_tests;
	logic [13:0] tbl [6] = '{14'h0fff, 14'h1fff, 14'h2fff, 14'h3fff,
		14'h0000, 14'h05a3};

	sdw_host_model u_sdw_host_model
	(
		.sync_n_o(sync_n), .sclk_o(sclk), .din_o(din)
	);

	sdw_ctrl u_sdw_ctrl
	(
		.clk_i(clk_i), .reset_i(reset_i), .sync_n_i(sync_n),
		.sclk_i(sclk), .din_i(din), .code_o(code_o),
		.tap_sel_o(tap_sel_o), .powered_o(powered_o), .pd_1k_o(pd_1k_o),
		.pd_100k_o(pd_100k_o), .pd_hiz_o(pd_hiz_o),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready)
	);

	initial
	begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	// ----------------------------------------------------------------
	// report and compare
	// ----------------------------------------------------------------
	task automatic tally_and_finish;
		$display("mismatches %0d n_tests %0d", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_out(input logic [1:0] m, input logic [11:0] c);
		chk({12'h0, pd_hiz_o, pd_100k_o, pd_1k_o, powered_o, 4'h0, code_o},
			{12'h0, m == 2'h3, m == 2'h2, m == 2'h1, m == 2'h0, 4'h0, c});
		chk({31'h0, tap_sel_o === (4096'h1 << c)}, 32'h1);
	endtask

	// ----------------------------------------------------------------
	// register bus; handshakes judged from values settled before the edge
	// ----------------------------------------------------------------
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_hs, w_hs, b_hs;
		@(posedge clk_i);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		for (int i = 0; i < 40; i++)
		begin
			@(negedge clk_i);
			aw_hs = s_axi_awvalid && s_axi_awready;
			w_hs  = s_axi_wvalid && s_axi_wready;
			b_hs  = s_axi_bvalid && s_axi_bready;
			bs    = s_axi_bresp;
			@(posedge clk_i);
			if (aw_hs)
				s_axi_awvalid <= 1'b0;
			if (w_hs)
				s_axi_wvalid <= 1'b0;
			if (b_hs)
			begin
				s_axi_bready <= 1'b0;
				return;
			end
		end
		mismatches++;
		tally_and_finish();
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		logic ar_hs, r_hs;
		@(posedge clk_i);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		for (int i = 0; i < 40; i++)
		begin
			@(negedge clk_i);
			ar_hs = s_axi_arvalid && s_axi_arready;
			r_hs  = s_axi_rvalid && s_axi_rready;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge clk_i);
			if (ar_hs)
				s_axi_arvalid <= 1'b0;
			if (r_hs)
			begin
				s_axi_rready <= 1'b0;
				return;
			end
		end
		mismatches++;
		tally_and_finish();
	endtask

	// don't-care bits carry the inverse of the mode bits
	task automatic frame(input logic [1:0] m, input logic [11:0] c,
		input int n);
		u_sdw_host_model.send({~m, m, c}, n);
		repeat (10) @(posedge clk_i);
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		{reset_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h8;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0;
		s_axi_wdata = 32'h0;
		repeat (3) @(posedge clk_i);
		reset_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		chk_out(2'h0, 12'h000);
		axi_rd(CTRL_OFS, rd, rs);
		chk({31'h0, rd[0]}, 32'h1);
		axi_rd(8'h0c, rd, rs);
		chk({30'h0, rs}, 32'h2);
		for (int k = 0; k < 6; k++)
		begin
			frame(tbl[k][13:12], tbl[k][11:0], 16);
			chk_out(tbl[k][13:12], tbl[k][11:0]);
		end
		frame(2'h3, 12'h123, 15);
		chk_out(2'h0, 12'h5a3);
		axi_wr(CTRL_OFS, 32'h0);
		chk({30'h0, bs}, 32'h0);
		frame(2'h1, 12'h777, 16);
		chk_out(2'h0, 12'h5a3);
		axi_wr(CTRL_OFS, 32'h1);
		frame(2'h2, 12'h800, 16);
		chk_out(2'h2, 12'h800);
		axi_wr(STATUS_OFS, 32'hffffffff);
		chk({30'h0, bs}, 32'h0);
		axi_wr(8'h0c, 32'h0);
		chk({30'h0, bs}, 32'h2);
		axi_rd(STATUS_OFS, rd, rs);
		chk(rd, 32'h0008000a);
		axi_rd(COUNT_OFS, rd, rs);
		chk(rd, 32'h00010007);
		reset_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		reset_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		chk_out(2'h0, 12'h000);
		axi_rd(COUNT_OFS, rd, rs);
		chk(rd, 32'h0);
		frame(2'h1, 12'h456, 17);
		chk_out(2'h1, 12'h456);
		tally_and_finish();
	end
endmodule
